// ### include/timer16_pkg.sv
// constants, field layouts and types shared by the 16-bit timer core
package timer16_pkg;
   // avalon byte addresses, one 32-bit word per 8-bit location
   localparam int ADDR_W = 6;
   localparam logic [5:0] OFS_CNT_LO = 6'h00;
   localparam logic [5:0] OFS_CNT_HI = 6'h04;
   localparam logic [5:0] OFS_CAP_LO = 6'h08;
   localparam logic [5:0] OFS_CAP_HI = 6'h0c;
   localparam logic [5:0] OFS_CMPA_LO = 6'h10;
   localparam logic [5:0] OFS_CMPA_HI = 6'h14;
   localparam logic [5:0] OFS_CTRL_A = 6'h18;
   localparam logic [5:0] OFS_CTRL_B = 6'h1c;
   localparam logic [5:0] OFS_FLAGS = 6'h20;
   localparam logic [5:0] OFS_IRQ_EN = 6'h24;
   localparam logic [5:0] OFS_CMP_CTRL = 6'h28;
   // bit positions in flags, irq enable and comparator control registers
   localparam int FLG_OVF = 0;
   localparam int FLG_CAP = 1;
   localparam int CMP_SEL_BIT = 0;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] TOP_8BIT = 16'h00ff;
   localparam logic [15:0] TOP_9BIT = 16'h01ff;
   localparam logic [15:0] TOP_10BIT = 16'h03ff;
   localparam logic [15:0] TOP_MAX = 16'hffff;
   localparam logic [15:0] BOTTOM = 16'h0000;
   // clock source codes
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   localparam int PRE_W = 10;
   localparam int TAP_DIV8 = 3;
   localparam int TAP_DIV64 = 6;
   localparam int TAP_DIV256 = 8;
   localparam int FILT_LEN = 4;
   typedef struct packed {
      logic filt_en;
      logic edge_rise;
      logic rsvd;
      logic [1:0] mode_hi;
      logic [2:0] csel;
   } ctrl_b_t;
   typedef enum logic {DIR_UP, DIR_DOWN} dir_t;
endpackage : timer16_pkg

// ### rtl/timer16_core.sv
// 16-bit up/down timer/counter with input capture behind an avalon-mm slave
// How it works
// RULE1 - counter visible as separate upper and lower bytes
// RULE2 - upper byte goes via shared holding byte
// RULE3 - each tick clears, increments or decrements per mode
// RULE4 - three-bit clock select; zero stops the timer
// RULE5 - counter readable and writable while stopped or running
// RULE6 - software counter write beats hardware count or clear
// RULE7 - four-bit mode split across control registers a, b
// RULE8 - overflow flag set per mode, can request interrupt
// RULE9 - bottom and top indications from the counter
// RULE10 - matching capture edge copies counter into capture value
// RULE11 - capture flag set in the copy cycle
// RULE12 - enabled capture flag requests irq, cleared on service
// RULE13 - writing one to capture flag clears it
// RULE14 - capture lower read loads holding byte for upper
// RULE15 - capture value writable only when it defines top
// RULE16 - comparator output selectable as capture trigger
// RULE17 - software clears capture flag after source change
// RULE18 - capture inputs synchronised; filter adds four clocks
// RULE19 - software guards shared holding byte against interrupts
// RULE20 - holding byte keeps written value until overwritten
// RULE21 - one holding byte; compare reads bypass it
// RULE22 - filter output changes after four equal samples
// RULE23 - top is fixed, compare a or capture per mode
// RULE24 - reset zeroes counter, capture, holding byte, flags, clock
//
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
module timer16_core
   import timer16_pkg::*;
#(
   parameter bit HAS_COMPARATOR = 1'b1
)(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic capture_pin_i,
   input wire logic comparator_output_i,
   input wire logic external_count_pin_i,
   input wire logic capture_irq_ack_i,
   input wire logic overflow_irq_ack_i,
   output logic capture_irq_o,
   output logic overflow_irq_o,
   output logic count_top_o,
   output logic count_bottom_o
);

   function automatic logic icr_is_top(input logic [3:0] m);
      return (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
   endfunction : icr_is_top

   function automatic logic dual_slope(input logic [3:0] m);
      return (m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
   endfunction : dual_slope

   function automatic logic fast_pwm(input logic [3:0] m);
      return (m inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf});
   endfunction : fast_pwm

   logic ack_ff;
   logic [31:0] rdata_ff;
   logic [7:0] temp_ff;
   logic [15:0] count_value_ff;
   logic [15:0] capture_value_ff;
   logic [15:0] compare_values_ff;
   logic [7:0] control_reg_a_ff;
   logic [7:0] control_reg_b_ff;
   logic [1:0] irq_en_ff;
   logic comparator_capture_select_ff;
   logic capture_flag_ff;
   logic overflow_flag_ff;
   dir_t dir_ff;
   logic [PRE_W-1:0] pre_ff;
   logic ext_s1_ff, ext_s2_ff, ext_d_ff;
   logic pin_s1_ff, pin_s2_ff, cmp_s1_ff, cmp_s2_ff;
   logic [FILT_LEN-2:0] filt_sh_ff;
   logic filt_out_ff;
   logic lvl_d_ff;

   ctrl_b_t ctrl_b;
   logic [3:0] waveform_mode_select;
   logic req, rd_go, wr_go, wr_lo;
   logic [7:0] wbyte;
   logic timer_tick;
   logic [15:0] top;
   logic src, lvl, cap_evt, ovf_evt;

   assign ctrl_b = ctrl_b_t'(control_reg_b_ff);
   assign waveform_mode_select = {ctrl_b.mode_hi, control_reg_a_ff[1:0]}; // RULE7

   // one wait state; read side effects at the first edge, writes at the accept edge
   assign req = avs_read_i || avs_write_i;
   assign avs_waitrequest_o = req && !ack_ff;
   assign rd_go = avs_read_i && !ack_ff;
   assign wr_go = avs_write_i && ack_ff;
   assign wr_lo = wr_go && avs_byteenable_i[0];
   assign wbyte = avs_writedata_i[7:0];
   assign avs_readdata_o = rdata_ff;

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         ack_ff <= 1'b0;
      else
         ack_ff <= req && !ack_ff;
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         rdata_ff <= 32'h0000_0000;
      else if (rd_go)
      begin
         rdata_ff <= 32'h0000_0000;
         unique case (avs_address_i)
            OFS_CNT_LO: rdata_ff[7:0] <= count_value_ff[7:0]; // RULE1 RULE5
            OFS_CNT_HI, OFS_CAP_HI: rdata_ff[7:0] <= temp_ff; // RULE2 RULE14
            OFS_CAP_LO: rdata_ff[7:0] <= capture_value_ff[7:0];
            OFS_CMPA_LO: rdata_ff[7:0] <= compare_values_ff[7:0];
            OFS_CMPA_HI: rdata_ff[7:0] <= compare_values_ff[15:8]; // RULE21
            OFS_CTRL_A: rdata_ff[7:0] <= control_reg_a_ff;
            OFS_CTRL_B: rdata_ff[7:0] <= control_reg_b_ff;
            OFS_FLAGS:
            begin
               rdata_ff[FLG_OVF] <= overflow_flag_ff;
               rdata_ff[FLG_CAP] <= capture_flag_ff;
            end
            OFS_IRQ_EN: rdata_ff[1:0] <= irq_en_ff;
            OFS_CMP_CTRL: rdata_ff[CMP_SEL_BIT] <= comparator_capture_select_ff;
            default: rdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   // single holding byte for every 16-bit location of this timer
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         temp_ff <= REG_RST; // RULE24
      else if (wr_lo && (avs_address_i inside {OFS_CNT_HI, OFS_CAP_HI, OFS_CMPA_HI}))
         temp_ff <= wbyte; // RULE20 RULE21
      else if (rd_go && avs_address_i == OFS_CNT_LO)
         temp_ff <= count_value_ff[15:8]; // RULE2
      else if (rd_go && avs_address_i == OFS_CAP_LO)
         temp_ff <= capture_value_ff[15:8]; // RULE14
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         control_reg_a_ff <= REG_RST;
         control_reg_b_ff <= REG_RST; // RULE24
         irq_en_ff <= 2'h0;
         comparator_capture_select_ff <= 1'b0;
         compare_values_ff <= CNT_RST;
      end
      else if (wr_lo)
      begin
         unique case (avs_address_i)
            OFS_CTRL_A: control_reg_a_ff <= wbyte;
            OFS_CTRL_B: control_reg_b_ff <= wbyte;
            OFS_IRQ_EN: irq_en_ff <= wbyte[1:0];
            OFS_CMP_CTRL: comparator_capture_select_ff <= wbyte[CMP_SEL_BIT] && HAS_COMPARATOR;
            OFS_CMPA_LO: compare_values_ff <= {temp_ff, wbyte};
            default: ;
         endcase
      end
   end

   // clock source selection
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         pre_ff <= '0;
      else
         pre_ff <= pre_ff + 1'b1;
   end

   always_ff @(posedge mclk_i)
   begin
      ext_s1_ff <= external_count_pin_i;
      ext_s2_ff <= ext_s1_ff;
      ext_d_ff <= ext_s2_ff;
   end

   always_comb
   begin
      unique case (ctrl_b.csel) // RULE4
         CS_STOP: timer_tick = 1'b0;
         CS_DIV1: timer_tick = 1'b1;
         CS_DIV8: timer_tick = &pre_ff[TAP_DIV8-1:0];
         CS_DIV64: timer_tick = &pre_ff[TAP_DIV64-1:0];
         CS_DIV256: timer_tick = &pre_ff[TAP_DIV256-1:0];
         CS_DIV1024: timer_tick = &pre_ff;
         CS_EXT_FALL: timer_tick = ext_d_ff && !ext_s2_ff;
         CS_EXT_RISE: timer_tick = ext_s2_ff && !ext_d_ff;
      endcase
   end

   always_comb
   begin
      unique case (waveform_mode_select) // RULE23
         4'h1, 4'h5: top = TOP_8BIT;
         4'h2, 4'h6: top = TOP_9BIT;
         4'h3, 4'h7: top = TOP_10BIT;
         4'h4, 4'h9, 4'hb, 4'hf: top = compare_values_ff;
         4'h8, 4'ha, 4'hc, 4'he: top = capture_value_ff;
         default: top = TOP_MAX;
      endcase
   end

   assign count_top_o = (count_value_ff == top); // RULE9
   assign count_bottom_o = (count_value_ff == BOTTOM); // RULE9

   // counter; software write wins over any tick in the same cycle
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         count_value_ff <= CNT_RST; // RULE24
         dir_ff <= DIR_UP;
      end
      else if (wr_lo && avs_address_i == OFS_CNT_LO)
         count_value_ff <= {temp_ff, wbyte}; // RULE2 RULE5 RULE6
      else if (timer_tick)
      begin
         if (!dual_slope(waveform_mode_select))
            count_value_ff <= count_top_o ? BOTTOM : count_value_ff + 16'h0001; // RULE3
         else if (dir_ff == DIR_UP)
         begin
            if (count_value_ff >= top)
            begin
               dir_ff <= DIR_DOWN;
               count_value_ff <= count_value_ff - 16'h0001; // RULE3
            end
            else
               count_value_ff <= count_value_ff + 16'h0001;
         end
         else if (count_bottom_o)
         begin
            dir_ff <= DIR_UP;
            count_value_ff <= count_value_ff + 16'h0001;
         end
         else
            count_value_ff <= count_value_ff - 16'h0001;
      end
   end

   // overflow at bottom for dual slope, at top for fast pwm, else at max
   always_comb
   begin
      if (dual_slope(waveform_mode_select))
         ovf_evt = timer_tick && dir_ff == DIR_DOWN && count_bottom_o;
      else if (fast_pwm(waveform_mode_select))
         ovf_evt = timer_tick && count_top_o;
      else
         ovf_evt = timer_tick && count_value_ff == TOP_MAX;
   end

   // capture trigger path: sync, optional filter, edge detect
   always_ff @(posedge mclk_i)
   begin
      pin_s1_ff <= capture_pin_i; // RULE18
      pin_s2_ff <= pin_s1_ff;
      cmp_s1_ff <= comparator_output_i;
      cmp_s2_ff <= cmp_s1_ff;
   end

   assign src = (HAS_COMPARATOR && comparator_capture_select_ff) ? cmp_s2_ff : pin_s2_ff; // RULE16

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         filt_sh_ff <= '0;
         filt_out_ff <= 1'b0;
      end
      else
      begin
         filt_sh_ff <= {filt_sh_ff[FILT_LEN-3:0], src};
         // the live sample is the fourth, so the filter costs exactly four clocks
         if (&{filt_sh_ff, src})
            filt_out_ff <= 1'b1; // RULE22
         else if (~|{filt_sh_ff, src})
            filt_out_ff <= 1'b0; // RULE22
      end
   end

   assign lvl = ctrl_b.filt_en ? filt_out_ff : src; // RULE18

   // follows the level through reset too, so a pin idling high gives no false edge
   always_ff @(posedge mclk_i)
   begin
      lvl_d_ff <= lvl;
   end

   assign cap_evt = (ctrl_b.edge_rise ? (lvl && !lvl_d_ff) : (!lvl && lvl_d_ff))
                    && !icr_is_top(waveform_mode_select); // RULE10

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         capture_value_ff <= CNT_RST; // RULE24
      else if (cap_evt)
         capture_value_ff <= count_value_ff; // RULE10
      else if (wr_lo && avs_address_i == OFS_CAP_LO && icr_is_top(waveform_mode_select))
         capture_value_ff <= {temp_ff, wbyte}; // RULE15
   end

   // flags: a hardware set in the clearing cycle wins
   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         capture_flag_ff <= 1'b0;
      else if (cap_evt)
         capture_flag_ff <= 1'b1; // RULE11
      else if (capture_irq_ack_i || (wr_lo && avs_address_i == OFS_FLAGS && wbyte[FLG_CAP]))
         capture_flag_ff <= 1'b0; // RULE12 RULE13 RULE17
   end

   always_ff @(posedge mclk_i)
   begin
      if (rst_i)
         overflow_flag_ff <= 1'b0;
      else if (ovf_evt)
         overflow_flag_ff <= 1'b1; // RULE8
      else if (overflow_irq_ack_i || (wr_lo && avs_address_i == OFS_FLAGS && wbyte[FLG_OVF]))
         overflow_flag_ff <= 1'b0;
   end

   assign capture_irq_o = capture_flag_ff && irq_en_ff[FLG_CAP]; // RULE12
   assign overflow_irq_o = overflow_flag_ff && irq_en_ff[FLG_OVF]; // RULE8

   default clocking dflt_cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   sequence seq_new_req;
      req && !ack_ff;
   endsequence

   sequence seq_cnt_lo_write;
      wr_lo && avs_address_i == OFS_CNT_LO;
   endsequence

   chk_bus_wait_state: assert property (seq_new_req |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("waitrequest not one cycle");
   chk_temp_on_read: assert property (rd_go && avs_address_i == OFS_CNT_LO // RULE2
      |=> temp_ff == $past(count_value_ff[15:8]))
      else $error("holding byte not loaded by lower read");
   chk_write_priority: assert property (seq_cnt_lo_write // RULE6
      |=> count_value_ff == {$past(temp_ff), $past(wbyte)})
      else $error("counter write lost");
   chk_clock_stopped: assert property (ctrl_b.csel == CS_STOP && !wr_lo // RULE4
      |=> $stable(count_value_ff))
      else $error("counter moved while stopped");
   chk_capture_copy: assert property (cap_evt // RULE10
      |=> capture_value_ff == $past(count_value_ff) && capture_flag_ff)
      else $error("capture copy or flag missing");
   chk_flag_w1c: assert property (!cap_evt && wr_lo && avs_address_i == OFS_FLAGS // RULE13
      && wbyte[FLG_CAP] |=> !capture_flag_ff)
      else $error("capture flag not cleared by write");
   chk_irq_ack: assert property (capture_irq_o && capture_irq_ack_i && !cap_evt // RULE12
      |=> !capture_irq_o)
      else $error("capture flag not cleared on service");
   chk_capture_lock: assert property (!icr_is_top(waveform_mode_select) && !cap_evt // RULE15
      |=> $stable(capture_value_ff))
      else $error("capture value changed without event");
   chk_temp_hold: assert property (!wr_lo && !rd_go |=> $stable(temp_ff)) // RULE20
      else $error("holding byte changed");
   chk_filter_ones: assert property (&{filt_sh_ff, src} |=> filt_out_ff) // RULE22
      else $error("filter output missed four ones");

endmodule : timer16_core

// ### verification/cpu_bus_model.sv
// cpu side of the timer: byte-wide avalon master
`timescale 1ns/10ps
module cpu_bus_model
   import timer16_pkg::*;
(
   input wire logic mclk_i,
   input wire logic waitrequest_i,
   input wire logic [31:0] readdata_i,
   output logic [ADDR_W-1:0] address_o,
   output logic read_o,
   output logic write_o,
   output logic [31:0] writedata_o,
   output logic [3:0] byteenable_o
);
   initial
   begin
      address_o = '0;
      read_o = 1'b0;
      write_o = 1'b0;
      writedata_o = '0;
      byteenable_o = 4'h1;
   end
   // strictly one transfer at a time, so an upper/lower pair is never split
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge mclk_i);
      address_o <= a;
      write_o <= wr;
      read_o <= !wr;
      writedata_o <= {24'h000000, d};
      // looked at right after each rising edge, before the slave's updates land;
      // only the bench watchdog ends a hang
      do
      begin
         @(posedge mclk_i);
      end
      while (waitrequest_i !== 1'b0);
      q = readdata_i[7:0];
      read_o <= 1'b0;
      write_o <= 1'b0;
   endtask : xfer
endmodule : cpu_bus_model

// ### verification/timer16_counter_capture_core_tb_top.sv
// self-checking bench for the 16-bit timer core
`timescale 1ns/10ps
module timer16_counter_capture_core_tb_top;
   import timer16_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [ADDR_W-1:0] adr;
   logic rd_s, wr_s, wt;
   logic [31:0] wd, rdat;
   logic [3:0] be;
   logic cap_pin = 1'b0, cmp_out = 1'b0, ext_pin = 1'b0, cap_ack = 1'b0, ovf_ack = 1'b0;
   logic cap_irq, ovf_irq, top, bot;
   logic [31:0] seed = 32'h00000032;
   logic [15:0] v;
   logic [7:0] x, y;
   int miscompares = 0;
   int samples_checked = 0;
   int n0, n1;
   logic [15:0] tops [1:3] = '{16'h00ff, 16'h01ff, 16'h03ff};
   always #5 mclk_i = ~mclk_i;
   timer16_core dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(adr),
      .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wd), .avs_byteenable_i(be),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .capture_pin_i(cap_pin),
      .comparator_output_i(cmp_out), .external_count_pin_i(ext_pin),
      .capture_irq_ack_i(cap_ack), .overflow_irq_ack_i(ovf_ack), .capture_irq_o(cap_irq),
      .overflow_irq_o(ovf_irq), .count_top_o(top), .count_bottom_o(bot));
   cpu_bus_model cpu_u (.mclk_i(mclk_i), .waitrequest_i(wt), .readdata_i(rdat),
      .address_o(adr), .read_o(rd_s), .write_o(wr_s), .writedata_o(wd), .byteenable_o(be));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      logic [7:0] q;
      cpu_u.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] q);
      cpu_u.xfer(1'b0, a, 8'h00, q);
   endtask : rd
   task automatic w16(input logic [ADDR_W-1:0] a, input logic [15:0] d);
      wr(a + 6'h04, d[15:8]);
      wr(a, d[7:0]);
   endtask : w16
   task automatic r16(input logic [ADDR_W-1:0] a, output logic [15:0] q);
      rd(a, q[7:0]);
      rd(a + 6'h04, q[15:8]);
   endtask : r16
   // drives the chosen capture source and counts clocks until the capture irq shows, at most 14
   task automatic cap_lat(input logic use_cmp, input logic lvl, output int n);
      @(posedge mclk_i);
      if (use_cmp)
         cmp_out <= lvl;
      else
         cap_pin <= lvl;
      n = 0;
      do
      begin
         @(negedge mclk_i);
         n++;
      end
      while (cap_irq !== 1'b1 && n < 14);
   endtask : cap_lat
   task automatic pulse_cap_ack;
      @(posedge mclk_i);
      cap_ack <= 1'b1;
      @(posedge mclk_i);
      cap_ack <= 1'b0;
      @(negedge mclk_i);
   endtask : pulse_cap_ack
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop
   initial
   begin
      #400000;
      miscompares++;
      report_and_stop();
   end
   initial
   begin
      repeat (20) @(posedge mclk_i);
      rst_i <= 1'b0;
      r16(OFS_CNT_LO, v);
      check(v, CNT_RST);
      r16(OFS_CAP_LO, v);
      check(v, 16'h0000);
      rd(OFS_FLAGS, x);
      check(16'(x), 16'(REG_RST));
      rd(OFS_CTRL_B, x);
      check(16'(x[2:0]), 16'(CS_STOP));
      check(16'(bot), 16'h0001);
      for (int i = 0; i < 4; i++)
      begin
         seed = xs(seed);
         w16(OFS_CNT_LO, seed[15:0]);
         r16(OFS_CNT_LO, v);
         check(v, seed[15:0]);
      end
      // one upper write serves two lower writes
      wr(OFS_CNT_HI, 8'h5a);
      wr(OFS_CNT_LO, 8'h01);
      wr(OFS_CMPA_LO, 8'h02);
      r16(OFS_CNT_LO, v);
      check(v, 16'h5a01);
      wr(OFS_CNT_HI, 8'h33);
      rd(OFS_CMPA_HI, x);
      check(16'(x), 16'h005a);
      for (int i = 1; i < 4; i++)
      begin
         wr(OFS_CTRL_A, 8'(i));
         w16(OFS_CNT_LO, tops[i]);
         @(negedge mclk_i);
         check(16'(top), 16'h0001);
         w16(OFS_CNT_LO, tops[i] - 16'h0001);
         @(negedge mclk_i);
         check(16'(top), 16'h0000);
      end
      wr(OFS_CTRL_A, 8'h00);
      wr(OFS_CTRL_B, 8'h08);
      w16(OFS_CNT_LO, 16'h5a02);
      @(negedge mclk_i);
      check(16'(top), 16'h0001);
      wr(OFS_CTRL_B, 8'h00);
      w16(OFS_CNT_LO, 16'h0010);
      wr(OFS_CTRL_B, 8'(CS_DIV1));
      rd(OFS_CNT_LO, x);
      rd(OFS_CNT_LO, y);
      check(16'(8'(y - x)), 16'h0003);
      wr(OFS_CTRL_B, 8'h00);
      wr(OFS_CTRL_A, 8'h01);
      w16(OFS_CNT_LO, 16'h00ff);
      wr(OFS_CTRL_B, 8'(CS_DIV1));
      rd(OFS_CNT_LO, x);
      rd(OFS_CNT_LO, y);
      check(16'(8'(x - y)), 16'h0003);
      wr(OFS_CTRL_B, 8'(CS_STOP));
      rd(OFS_CNT_LO, x);
      rd(OFS_CNT_LO, y);
      check(16'(y), 16'(x));
      wr(OFS_CTRL_A, 8'h00);
      wr(OFS_CTRL_B, 8'(CS_DIV1));
      // the running tick must lose against the written value
      w16(OFS_CNT_LO, 16'h4000);
      rd(OFS_CNT_LO, x);
      check(16'(x), 16'h0001);
      w16(OFS_CNT_LO, 16'hfff0);
      repeat (30) @(posedge mclk_i);
      wr(OFS_CTRL_B, 8'(CS_STOP));
      wr(OFS_IRQ_EN, 8'h01);
      @(negedge mclk_i);
      check(16'(ovf_irq), 16'h0001);
      @(posedge mclk_i);
      ovf_ack <= 1'b1;
      @(posedge mclk_i);
      ovf_ack <= 1'b0;
      rd(OFS_FLAGS, x);
      check(16'(x[FLG_OVF]), 16'h0000);
      w16(OFS_CNT_LO, 16'h0000);
      wr(OFS_CTRL_B, 8'(CS_EXT_RISE));
      repeat (20)
      begin
         repeat (2) @(posedge mclk_i);
         ext_pin <= ~ext_pin;
      end
      repeat (4) @(posedge mclk_i);
      wr(OFS_CTRL_B, 8'(CS_STOP));
      rd(OFS_CNT_LO, x);
      check(16'(x), 16'h000a);
      w16(OFS_CNT_LO, 16'h1234);
      wr(OFS_CTRL_B, 8'h40);
      wr(OFS_IRQ_EN, 8'h02);
      cap_lat(1'b0, 1'b1, n0);
      check(16'(cap_irq), 16'h0001);
      r16(OFS_CAP_LO, v);
      check(v, 16'h1234);
      pulse_cap_ack();
      check(16'(cap_irq), 16'h0000);
      cap_lat(1'b0, 1'b0, n1);
      check(16'(cap_irq), 16'h0000);
      wr(OFS_CTRL_B, 8'h00);
      cap_lat(1'b0, 1'b1, n1);
      check(16'(cap_irq), 16'h0000);
      cap_lat(1'b0, 1'b0, n1);
      check(16'(cap_irq), 16'h0001);
      wr(OFS_FLAGS, 8'h02);
      rd(OFS_FLAGS, x);
      check(16'(x[FLG_CAP]), 16'h0000);
      wr(OFS_CTRL_B, 8'hc0);
      cap_pin <= 1'b0;
      repeat (14) @(posedge mclk_i);
      wr(OFS_FLAGS, 8'h02);
      @(posedge mclk_i);
      cap_pin <= 1'b1;
      repeat (2) @(posedge mclk_i);
      cap_pin <= 1'b0;
      repeat (14) @(negedge mclk_i);
      check(16'(cap_irq), 16'h0000);
      cap_lat(1'b0, 1'b1, n1);
      check(16'(n1 - n0), 16'h0004);
      wr(OFS_CTRL_B, 8'h40);
      wr(OFS_CMP_CTRL, 8'h01);
      wr(OFS_FLAGS, 8'h02);
      cap_lat(1'b1, 1'b1, n1);
      check(16'(n1), 16'(n0));
      wr(OFS_FLAGS, 8'h02);
      w16(OFS_CAP_LO, 16'habcd);
      r16(OFS_CAP_LO, v);
      check(v, 16'h1234);
      wr(OFS_CTRL_B, 8'h18);
      w16(OFS_CAP_LO, 16'habcd);
      r16(OFS_CAP_LO, v);
      check(v, 16'habcd);
      rd(6'h3c, x);
      check(16'(x), 16'h0000);
      report_and_stop();
   end
endmodule : timer16_counter_capture_core_tb_top
